// ---- core/ims_pkg.sv ----
package ims_pkg;

   localparam logic [15:0] IMS_DUMMY_ADDR  = 16'hFFFF;
   localparam logic [15:0] IMS_OFS_STEP    = 16'h0001;
   localparam logic [15:0] IMS_RET_STEP    = 16'h0002;
   localparam logic [15:0] IMS_STACK_STEP  = 16'h0001;
   localparam logic [15:0] IMS_RESET_ADDR  = 16'hFFFF;
   localparam logic [7:0]  IMS_RESET_DATA  = 8'h00;
   localparam logic [2:0]  IMS_CYC_JUMP    = 3'h3;
   localparam logic [2:0]  IMS_CYC_ACC     = 3'h4;
   localparam logic [2:0]  IMS_CYC_WIDE    = 3'h5;
   localparam logic [2:0]  IMS_CYC_LONG    = 3'h6;

   typedef enum logic [3:0] {
      jump_op,
      acc_read_op,
      store_accumulator_op,
      load_stack_pointer_op,
      load_index_op,
      load_double_op,
      store_stack_pointer_op,
      store_index_op,
      store_double_op,
      modify_op,
      test_operand_op,
      compare_index_op,
      subtract_double_op,
      add_double_op,
      call_subroutine_op
   } ims_op_type;

   function automatic logic ims_is_load16(input ims_op_type op);
      return op inside {load_stack_pointer_op, load_index_op, load_double_op};
   endfunction

   function automatic logic ims_is_store16(input ims_op_type op);
      return op inside {store_stack_pointer_op, store_index_op, store_double_op};
   endfunction

   function automatic logic ims_is_arith16(input ims_op_type op);
      return op inside {compare_index_op, subtract_double_op, add_double_op};
   endfunction

   function automatic logic [2:0] ims_op_cycles(input ims_op_type op);
      logic [2:0] n;
      n = IMS_CYC_LONG;
      if (op == jump_op)
         n = IMS_CYC_JUMP;
      else if (op == acc_read_op || op == store_accumulator_op)
         n = IMS_CYC_ACC;
      else if (ims_is_load16(op) || ims_is_store16(op))
         n = IMS_CYC_WIDE;
      return n;
   endfunction

endpackage

// ---- core/ims_ea_if.sv ----
`timescale 1ns/1ns
interface ims_ea_if;
   logic [15:0] index;
   logic [7:0]  offset;
   logic [15:0] ea;
   logic [15:0] ea_next;

   modport calc (input index, input offset, output ea, output ea_next);
   modport user (output index, output offset, input ea, input ea_next);
endinterface

// ---- core/ims_ea_calc.sv ----
`timescale 1ns/1ns
module ims_ea_calc
   import ims_pkg::*;
(
   ims_ea_if.calc ea_bus
);

   wire [15:0] sum;

   assign sum            = ea_bus.index + {8'h00, ea_bus.offset};
   assign ea_bus.ea      = sum;
   assign ea_bus.ea_next = sum + IMS_OFS_STEP;

endmodule

// ---- core/ims_sequencer.sv ----
`timescale 1ns/1ns
// Function
// - indexed jump is 3 cycles: opcode, offset, dummy read at FFFF.
// - 8-bit indexed ops and accumulator store: 4 cycles, cycle 4 at effective address.
// - 16-bit indexed loads: 5 cycles, high byte then low byte at next address.
// - 16-bit indexed stores: 5 cycles, write high then low byte.
// - read-modify-write: read cycle 4, dummy FFFF cycle 5, write cycle 6.
// - test instruction: cycle 6 is a read at FFFF, not a write.
// - 16-bit compare/add/subtract: read high, read low, then dummy FFFF.
// - indexed call: 6 cycles, cycle 4 reads first subroutine opcode.
// - call writes return low at stack pointer, then high at pointer minus one.
module ims_sequencer
   import ims_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire ims_op_type  op,
   input  wire logic [15:0] opcode_addr,
   input  wire logic [15:0] index_reg,
   input  wire logic [15:0] stack_ptr,
   input  wire logic [15:0] store_data,
   input  wire logic [7:0]  rmw_result,
   input  wire logic [7:0]  data_lines_in,
   output logic      [15:0] address_lines,
   output logic             rw,
   output logic      [7:0]  data_lines_out,
   output logic             data_lines_oe_n,
   output logic             busy,
   output logic             done,
   output logic      [7:0]  opcode_byte,
   output logic      [15:0] read_data,
   output logic      [15:0] jump_target
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH_OP,
      ST_FETCH_OFS,
      ST_DUMMY,
      ST_ACCESS4,
      ST_ACCESS5,
      ST_ACCESS6
   } ims_state_type;

   ims_state_type state;
   ims_state_type next_state;

   logic             rst_meta;
   logic             rst_n;
   ims_op_type       op_q;
   logic      [15:0] pc_q;
   logic      [15:0] ret_q;
   logic      [15:0] sp_q;
   logic      [15:0] store_q;
   logic      [7:0]  offset_q;
   logic      [15:0] next_addr;
   logic             next_write;
   logic      [7:0]  next_dout;

   ims_ea_if ea_bus ();

   ims_ea_calc u_ea (
      .ea_bus (ea_bus)
   );

   assign ea_bus.index  = index_reg;
   assign ea_bus.offset = offset_q;

   // Reset synchroniser, first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   function automatic logic [2:0] cycle_of(input ims_state_type s);
      logic [2:0] n;
      unique case (s)
         ST_IDLE:      n = 3'h0;
         ST_FETCH_OP:  n = 3'h1;
         ST_FETCH_OFS: n = 3'h2;
         ST_DUMMY:     n = 3'h3;
         ST_ACCESS4:   n = 3'h4;
         ST_ACCESS5:   n = 3'h5;
         ST_ACCESS6:   n = 3'h6;
      endcase
      return n;
   endfunction

   wire is_call   = (op_q == call_subroutine_op);
   wire is_modify = (op_q == modify_op);
   wire is_test   = (op_q == test_operand_op);
   wire is_st16   = ims_is_store16(op_q);
   wire is_wide   = ims_is_load16(op_q) || ims_is_store16(op_q) || ims_is_arith16(op_q);
   wire last_cyc  = (state != ST_IDLE) && (cycle_of(state) == ims_op_cycles(op_q));

   assign busy = (state != ST_IDLE);

   // Sequence length follows the instruction class
   always_comb begin
      next_state = state;
      if (last_cyc) begin
         next_state = ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE:      next_state = start ? ST_FETCH_OP : ST_IDLE;
            ST_FETCH_OP:  next_state = ST_FETCH_OFS;
            ST_FETCH_OFS: next_state = ST_DUMMY;
            ST_DUMMY:     next_state = ST_ACCESS4;
            ST_ACCESS4:   next_state = ST_ACCESS5;
            ST_ACCESS5:   next_state = ST_ACCESS6;
            ST_ACCESS6:   next_state = ST_IDLE;
         endcase
      end
   end

   // Bus values for the cycle about to start, so the pins come from flops
   always_comb begin
      next_addr  = IMS_DUMMY_ADDR;
      next_write = 1'b0;
      next_dout  = IMS_RESET_DATA;
      unique case (next_state)
         ST_IDLE: begin
            next_addr = IMS_DUMMY_ADDR;
         end
         ST_FETCH_OP: begin
            next_addr = opcode_addr;
         end
         ST_FETCH_OFS: begin
            next_addr = pc_q + IMS_OFS_STEP;
         end
         ST_DUMMY: begin
            next_addr = IMS_DUMMY_ADDR;
         end
         ST_ACCESS4: begin
            next_addr  = ea_bus.ea;
            next_write = is_st16 || (op_q == store_accumulator_op);
            next_dout  = is_st16 ? store_q[15:8] : store_q[7:0];
         end
         ST_ACCESS5: begin
            if (is_call) begin
               next_addr  = sp_q;
               next_write = 1'b1;
               next_dout  = ret_q[7:0];
            end else if (is_modify || is_test) begin
               next_addr = IMS_DUMMY_ADDR;
            end else begin
               next_addr  = ea_bus.ea_next;
               next_write = is_st16;
               next_dout  = store_q[7:0];
            end
         end
         ST_ACCESS6: begin
            if (is_call) begin
               next_addr  = sp_q - IMS_STACK_STEP;
               next_write = 1'b1;
               next_dout  = ret_q[15:8];
            end else if (is_modify) begin
               next_addr  = ea_bus.ea;
               next_write = 1'b1;
               next_dout  = rmw_result;
            end else begin
               next_addr = IMS_DUMMY_ADDR;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state           <= ST_IDLE;
         address_lines   <= IMS_RESET_ADDR;
         rw              <= 1'b1;
         data_lines_out  <= IMS_RESET_DATA;
         data_lines_oe_n <= 1'b1;
         done            <= 1'b0;
      end else begin
         state           <= next_state;
         address_lines   <= next_addr;
         rw              <= !next_write;
         data_lines_out  <= next_dout;
         data_lines_oe_n <= !next_write;
         done            <= last_cyc;
      end
   end

   // Operands latched once per instruction; index is only read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q    <= jump_op;
         pc_q    <= 16'h0000;
         ret_q   <= 16'h0000;
         sp_q    <= 16'h0000;
         store_q <= 16'h0000;
      end else if (state == ST_IDLE && start) begin
         op_q    <= op;
         pc_q    <= opcode_addr;
         ret_q   <= opcode_addr + IMS_RET_STEP;
         sp_q    <= stack_ptr;
         store_q <= store_data;
      end
   end

   // Read data sampled at the end of each non-dummy read cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opcode_byte <= 8'h00;
         offset_q    <= 8'h00;
         read_data   <= 16'h0000;
         jump_target <= 16'h0000;
      end else begin
         if (state == ST_FETCH_OP)
            opcode_byte <= data_lines_in;
         if (state == ST_FETCH_OFS)
            offset_q <= data_lines_in;
         if (state == ST_DUMMY)
            jump_target <= ea_bus.ea;
         if (state == ST_ACCESS4 && rw)
            read_data <= is_wide ? {data_lines_in, 8'h00} : {8'h00, data_lines_in};
         if (state == ST_ACCESS5 && rw && is_wide)
            read_data <= {read_data[15:8], data_lines_in};
      end
   end

endmodule

// ---- test/ims_sequencer_chk.sv ----
`timescale 1ns/1ns
module ims_sequencer_chk
   import ims_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        start,
   input wire ims_op_type  op,
   input wire logic [15:0] opcode_addr,
   input wire logic [15:0] stack_ptr,
   input wire logic [15:0] address_lines,
   input wire logic        rw,
   input wire logic        data_lines_oe_n,
   input wire logic        busy,
   input wire logic        done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire taken = start && !busy;

   a_fetch_opcode: assert property (taken |=> address_lines == $past(opcode_addr) && rw)
      else $error("opcode fetch address wrong");
   a_offset_fetch: assert property (taken |=> ##1 address_lines == $past(opcode_addr, 2) + 16'h0001)
      else $error("offset fetch address wrong");
   a_dummy_third: assert property (taken |=> ##2 address_lines == 16'hFFFF && rw)
      else $error("third cycle not a dummy read");
   a_jump_length: assert property (taken && op == jump_op |=> ##3 done)
      else $error("jump length wrong");
   a_store_busy: assert property (taken && op == store_double_op |=> busy [*5] ##1 done && !busy)
      else $error("wide store length wrong");
   a_modify_order: assert property (taken && op == modify_op |=> ##4 address_lines == 16'hFFFF ##1 !rw)
      else $error("modify sequence wrong");
   a_test_no_write: assert property (taken && op == test_operand_op |=> ##5 rw && address_lines == 16'hFFFF)
      else $error("test op wrote in cycle six");
   a_call_stack: assert property (taken && op == call_subroutine_op |=> ##4 !rw && address_lines == $past(stack_ptr, 5) ##1 !rw && address_lines == $past(stack_ptr, 6) - 16'h0001)
      else $error("call stack writes wrong");
   a_drive_write: assert property (data_lines_oe_n == rw)
      else $error("data drive not tied to write");

   c_jump: cover property (taken && op == jump_op);
   c_modify: cover property (taken && op == modify_op);
   c_call: cover property (taken && op == call_subroutine_op);
endmodule

bind ims_sequencer ims_sequencer_chk ims_sequencer_chk_inst (.clk, .nrst, .start, .op,
   .opcode_addr, .stack_ptr, .address_lines, .rw, .data_lines_oe_n, .busy, .done);

// ---- test/ims_mem_model.sv ----
`timescale 1ns/1ns
module ims_mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] address_lines,
   input  wire logic        rw,
   input  wire logic [7:0]  data_lines_out,
   output logic      [7:0]  data_lines_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] junk = 8'h00;

   initial begin
      for (int a = 0; a < 65536; a++) begin
         mem[a] = 8'(a) ^ 8'h5A;
      end
   end
   assign data_lines_in = rw ? mem[address_lines] : junk;
   always @(posedge clk) begin
      // Changing junk so write cycles never echo stale data
      junk <= junk + 8'h3B;
      if (!rw) begin
         mem[address_lines] <= data_lines_out;
      end
   end
endmodule

// ---- test/test_ims_sequencer.sv ----
`timescale 1ns/1ns
module test_ims_sequencer
   import ims_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        start = 1'b0;
   ims_op_type  op = jump_op;
   logic [15:0] opcode_addr = 16'h0000;
   logic [15:0] index_reg = 16'h0000;
   logic [15:0] stack_ptr = 16'h0000;
   logic [15:0] store_data = 16'h0000;
   logic [7:0]  rmw_result = 8'h00;
   logic [7:0]  data_lines_in;
   logic [7:0]  data_lines_out;
   logic [7:0]  opcode_byte;
   logic [15:0] address_lines;
   logic [15:0] read_data;
   logic [15:0] jump_target;
   logic        rw;
   logic        data_lines_oe_n;
   logic        busy;
   logic        done;
   logic [15:0] ga [1:6];
   logic        gr [1:6];
   logic [15:0] ea;
   int          mismatches = 0;
   int          n_tests = 0;

   always #25 clk = ~clk;

   ims_sequencer ims_sequencer_inst (.clk, .nrst, .start, .op, .opcode_addr, .index_reg,
      .stack_ptr, .store_data, .rmw_result, .data_lines_in, .address_lines, .rw,
      .data_lines_out, .data_lines_oe_n, .busy, .done, .opcode_byte, .read_data, .jump_target);
   ims_mem_model ims_mem_model_inst (.clk, .address_lines, .rw, .data_lines_out, .data_lines_in);

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int k, input logic [15:0] a, input logic r);
      chk(ga[k], a);
      chk(16'(gr[k]), 16'(r));
   endtask

   // Start stays high in cycle 1, where it must be ignored
   task automatic issue(input ims_op_type o, input int n, input logic [15:0] oa,
                        input logic [15:0] ix);
      op = o;
      opcode_addr = oa;
      index_reg = ix;
      start = 1'b1;
      ea = ix + {8'h00, pat(oa + 16'h0001)};
      for (int k = 1; k <= n; k++) begin
         @(negedge clk);
         if (k == 2) start = 1'b0;
         ga[k] = address_lines;
         gr[k] = rw;
         chk(16'(busy), 16'h0001);
      end
      @(negedge clk);
      chk(16'(done), 16'h0001);
      chk(16'(busy), 16'h0000);
      chk_cyc(1, oa, 1'b1);
      chk_cyc(2, oa + 16'h0001, 1'b1);
      chk_cyc(3, 16'hFFFF, 1'b1);
   endtask

   task automatic t_jump();
      issue(jump_op, 3, 16'h12A5, 16'h00F0);
      chk(16'(opcode_byte), 16'(pat(16'h12A5)));
      chk(jump_target, 16'h01EC);
   endtask

   task automatic t_acc();
      issue(acc_read_op, 4, 16'h20C3, 16'hFFA0);
      chk_cyc(4, ea, 1'b1);
      chk(read_data, {8'h00, pat(ea)});
      chk(jump_target, 16'h003E);
      store_data = 16'h9D3C;
      issue(store_accumulator_op, 4, 16'h2101, 16'h3000);
      chk_cyc(4, 16'h3058, 1'b0);
      chk(16'(ims_mem_model_inst.mem[ea]), 16'h003C);
   endtask

   task automatic t_wide_read();
      ims_op_type ops [6] = '{load_stack_pointer_op, load_index_op, load_double_op,
                              compare_index_op, subtract_double_op, add_double_op};
      foreach (ops[i]) begin
         issue(ops[i], (i < 3) ? 5 : 6, 16'h4000 + 16'(i * 16), 16'h5000);
         chk_cyc(4, ea, 1'b1);
         chk_cyc(5, ea + 16'h0001, 1'b1);
         if (i >= 3) chk_cyc(6, 16'hFFFF, 1'b1);
         chk(read_data, {pat(ea), pat(ea + 16'h0001)});
      end
   endtask

   task automatic t_store16();
      ims_op_type ops [3] = '{store_stack_pointer_op, store_index_op, store_double_op};
      foreach (ops[i]) begin
         store_data = 16'hA1B2 + 16'(i);
         issue(ops[i], 5, 16'h6000 + 16'(i * 16), 16'h7000);
         chk_cyc(4, ea, 1'b0);
         chk_cyc(5, ea + 16'h0001, 1'b0);
         chk(16'(ims_mem_model_inst.mem[ea]), 16'(store_data[15:8]));
         chk(16'(ims_mem_model_inst.mem[ea + 16'h0001]), 16'(store_data[7:0]));
      end
   endtask

   task automatic t_modify();
      rmw_result = 8'hC7;
      issue(modify_op, 6, 16'h8000, 16'h9000);
      chk_cyc(4, ea, 1'b1);
      chk_cyc(5, 16'hFFFF, 1'b1);
      chk_cyc(6, ea, 1'b0);
      chk(16'(ims_mem_model_inst.mem[ea]), 16'h00C7);
      issue(test_operand_op, 6, 16'h8100, 16'h9100);
      chk_cyc(6, 16'hFFFF, 1'b1);
      chk(16'(ims_mem_model_inst.mem[ea]), 16'(pat(ea)));
   endtask

   task automatic t_call();
      stack_ptr = 16'hB0F0;
      issue(call_subroutine_op, 6, 16'hA0FE, 16'hC000);
      chk_cyc(4, 16'hC0A5, 1'b1);
      chk(read_data, 16'h00FF);
      chk_cyc(5, 16'hB0F0, 1'b0);
      chk_cyc(6, 16'hB0EF, 1'b0);
      chk(16'(ims_mem_model_inst.mem[16'hB0F0]), 16'h0000);
      chk(16'(ims_mem_model_inst.mem[16'hB0EF]), 16'h00A1);
   endtask

   // Reset in mid-instruction must abandon the pending write
   task automatic t_reset();
      op = modify_op;
      opcode_addr = 16'hD000;
      index_reg = 16'hE000;
      rmw_result = 8'h11;
      start = 1'b1;
      repeat (2) @(negedge clk);
      start = 1'b0;
      nrst = 1'b0;
      @(negedge clk);
      chk(address_lines, 16'hFFFF);
      chk(16'(rw), 16'h0001);
      chk(16'(busy), 16'h0000);
      chk(16'(data_lines_oe_n), 16'h0001);
      repeat (6) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk(16'(ims_mem_model_inst.mem[16'hE05B]), 16'h0001);
      issue(jump_op, 3, 16'h12A5, 16'h00F0);
      chk(16'(opcode_byte), 16'h00FF);
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Back-to-back: each issue from t_acc to t_call starts in the previous done cycle
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      t_jump();
      t_acc();
      t_wide_read();
      t_store16();
      t_modify();
      t_call();
      t_reset();
      print_verdict();
   end

   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
endmodule
